// >>> logic/sise_pkg.sv
// Package of offsets, bit positions, reset values and constants for the SPI interrupt block.
package sise_pkg;

  localparam int unsigned SISE_ADDR_W = 8;
  localparam int unsigned SISE_NBITS = 14;

  // Register byte offsets.
  localparam logic [7:0] SISE_OFF_GLOBAL_IRQ_GATE_REG = 8'h1C;
  localparam logic [7:0] SISE_OFF_INTERRUPT_STATUS = 8'h20;
  localparam logic [7:0] SISE_OFF_INTERRUPT_ENABLE = 8'h28;

  // Field positions.
  localparam int unsigned SISE_GLOBAL_IRQ_GATE_BIT = 31;
  localparam int unsigned SISE_B_CMD_ERR = 13;
  localparam int unsigned SISE_B_LOOP_ERR = 12;
  localparam int unsigned SISE_B_MSB_ERR = 11;
  localparam int unsigned SISE_B_SLV_MODE_ERR = 10;
  localparam int unsigned SISE_B_POL_PHA_ERR = 9;
  localparam int unsigned SISE_B_RX_NOT_EMPTY = 8;
  localparam int unsigned SISE_B_SLAVE_SELECTED = 7;
  localparam int unsigned SISE_B_TX_HALF_EMPTY = 6;
  localparam int unsigned SISE_B_RX_OVERRUN = 5;
  localparam int unsigned SISE_B_RX_FULL = 4;
  localparam int unsigned SISE_B_TX_UNDERRUN = 3;
  localparam int unsigned SISE_B_TX_EMPTY = 2;
  localparam int unsigned SISE_B_DISABLED_TARGET_FAULT = 1;
  localparam int unsigned SISE_B_MASTER_SELECT_FAULT = 0;

  // Mask of the enable bits that only matter in dual or quad operation.
  localparam logic [13:0] SISE_DUAL_QUAD_MASK = 14'h3E00;

  // Reset values.
  localparam logic [13:0] SISE_STATUS_RST = 14'h0000;
  localparam logic [13:0] SISE_ENABLE_RST = 14'h0000;
  localparam logic SISE_GATE_RST = 1'b0;

  // Transmit occupancy at the half-depth point for the two FIFO depths.
  localparam logic [7:0] SISE_HALF_16 = 8'h08;
  localparam logic [7:0] SISE_HALF_256 = 8'h80;

endpackage : sise_pkg

// >>> logic/sise_irq_ctrl.sv
// Interrupt status, enable and global gate logic of the SPI master/slave core.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R01 - Standard slave with FIFOs: first received beat strobes status bit 8.
// R02 - Without FIFOs bit 8 reads zero; it means nothing in dual/quad.
// R03 - Standard slave only: being selected by a master strobes bit 7.
// R04 - With FIFOs, occupancy dropping across half depth strobes bit 6.
// R05 - Storing into a full receive buffer strobes overrun bit 5; the code never sets it in dual/quad slave operation.
// R06 - Bit 4 strobes per element without FIFOs, on FIFO fill with FIFOs.
// R07 - Enabled standard slave requesting data from empty transmit strobes bit 3.
// R08 - On underrun the slave shifts out an all-zero element.
// R09 - Bit 2 strobes per element without FIFOs, on FIFO drain with FIFOs.
// R10 - Master starts no transfer while transmit empty bit is one.
// R11 - Select while disabled slave sets bit 1, held while condition stays.
// R12 - Select input active while master sets bit 0 at once.
// R13 - Writing one toggles a status bit; writing zero leaves it.
// R14 - Interrupt asserts when any status bit and matching enable are set.
// R15 - Enable register bits 13..0 read/write, cleared on reset.
// R16 - Enable bits 13..9 matter only in dual or quad operation.
// R17 - Slave-selected enable has no effect while operating as master.
// R18 - Without FIFOs the receive-not-empty enable has no effect.
// R19 - In execute-in-place builds only the two XIP registers are exposed.
// R20 - Global gate bit 31, reset zero, gates the combined interrupt.
// R21 - Dual/quad: polarity/phase programmed 01 or 10 sets bit 9.
// R22 - A hardware set and a toggle in one clock leave the bit set.
// R23 - Bits the configuration cannot produce are never set by hardware.
module sise_irq_ctrl
  import sise_pkg::*;
(
  input wire logic sys_clk, // Bus clock, 25 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  input wire logic [7:0] reg_addr, // Register byte address.
  input wire logic [31:0] reg_wdata, // Register write data.
  output logic [31:0] reg_rdata, // Read data, valid with reg_rvalid.
  output logic reg_rvalid, // One-cycle read answer.
  input wire logic cfg_fifo_present, // Core built with FIFOs.
  input wire logic cfg_depth_256, // FIFO depth 256 instead of 16.
  input wire logic cfg_dual_quad, // Dual or quad operation.
  input wire logic cfg_master, // Configured as master.
  input wire logic cfg_xip, // Execute-in-place build.
  input wire logic serial_enable_bit, // Core enable.
  input wire logic cfg_cpol, // Clock polarity control bit.
  input wire logic cfg_cpha, // Clock phase control bit.
  input wire logic ss_active, // Slave select input active.
  input wire logic rx_first_beat, // First beat entered the receive FIFO.
  input wire logic [7:0] tx_occupancy, // Transmit FIFO occupancy value.
  input wire logic rx_store_try, // Engine stores a completed element.
  input wire logic rx_buf_full, // Receive buffer is full.
  input wire logic element_end, // End of an element transfer.
  input wire logic rx_fifo_filled, // This transfer filled the receive FIFO.
  input wire logic tx_req_empty, // Transmit data requested while empty.
  input wire logic tx_fifo_emptied, // This transfer emptied the transmit FIFO.
  input wire logic cmd_err_strobe, // Dual/quad command error.
  input wire logic loop_err_strobe, // Dual/quad loopback error.
  input wire logic msb_err_strobe, // Dual/quad bit-order error.
  input wire logic slv_mode_err_strobe, // Dual/quad slave-mode error.
  output logic irq, // Combined interrupt request.
  output logic tx_load_zero, // Load all-zero element into shift register.
  output logic master_start_allow // Master may start a transfer.
);

  typedef struct packed {
    logic [13:0] status;
    logic [13:0] enable;
    logic gate;
    logic ss_prev;
    logic [7:0] occ_prev;
    logic irq;
    logic [31:0] rdata;
    logic rvalid;
    logic load_zero;
    logic start_allow;
  } sise_state_t;

  sise_state_t st_q;
  sise_state_t st_d;
  logic [1:0] rst_sync_q;
  logic rst_n;

  function automatic logic sise_hit(input logic [7:0] addr, input logic [7:0] off, input logic xip);
    sise_hit = (addr == off) && !xip; // R19
  endfunction : sise_hit

  // Enable mask seen by the interrupt output for the current configuration.
  function automatic logic [13:0] sise_eff_en(input logic [13:0] en, input logic dq, input logic mst,
                                              input logic fifo);
    logic [13:0] m;
    m = en;
    if (!dq) begin
      m = m & ~SISE_DUAL_QUAD_MASK; // R16
    end
    if (mst) begin
      m[SISE_B_SLAVE_SELECTED] = 1'b0; // R17
    end
    if (!fifo) begin
      m[SISE_B_RX_NOT_EMPTY] = 1'b0; // R18
    end
    sise_eff_en = m;
  endfunction : sise_eff_en

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  logic [13:0] set_v;
  logic [13:0] tog_v;
  logic [7:0] half_v;
  logic std_slave;

  always_comb begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    st_d.load_zero = 1'b0;
    set_v = '0;
    tog_v = '0;
    std_slave = !cfg_dual_quad && !cfg_master;
    half_v = cfg_depth_256 ? SISE_HALF_256 : SISE_HALF_16;
    st_d.ss_prev = ss_active;
    st_d.occ_prev = tx_occupancy;
    set_v[SISE_B_RX_NOT_EMPTY] = cfg_fifo_present && std_slave && rx_first_beat; // R01 R02 R23
    set_v[SISE_B_SLAVE_SELECTED] = std_slave && ss_active && !st_q.ss_prev; // R03
    set_v[SISE_B_TX_HALF_EMPTY] = cfg_fifo_present && (st_q.occ_prev == half_v) &&
                                  (tx_occupancy == half_v - 8'h01); // R04
    set_v[SISE_B_RX_OVERRUN] = rx_store_try && rx_buf_full && (!cfg_dual_quad || cfg_master); // R05
    set_v[SISE_B_RX_FULL] = element_end && (!cfg_fifo_present || rx_fifo_filled); // R06
    set_v[SISE_B_TX_UNDERRUN] = std_slave && serial_enable_bit && element_end && tx_req_empty; // R07
    set_v[SISE_B_TX_EMPTY] = element_end && (!cfg_fifo_present || tx_fifo_emptied); // R09
    set_v[SISE_B_DISABLED_TARGET_FAULT] = !cfg_master && !serial_enable_bit && ss_active; // R11
    set_v[SISE_B_MASTER_SELECT_FAULT] = cfg_master && ss_active && !st_q.ss_prev; // R12
    set_v[SISE_B_POL_PHA_ERR] = cfg_dual_quad && (cfg_cpol != cfg_cpha); // R21
    set_v[SISE_B_SLV_MODE_ERR] = cfg_dual_quad && slv_mode_err_strobe; // R23
    set_v[SISE_B_MSB_ERR] = cfg_dual_quad && msb_err_strobe;
    set_v[SISE_B_LOOP_ERR] = cfg_dual_quad && loop_err_strobe;
    set_v[SISE_B_CMD_ERR] = cfg_dual_quad && cmd_err_strobe;
    // The slave has nothing valid to send, so a zero element goes out instead.
    st_d.load_zero = set_v[SISE_B_TX_UNDERRUN]; // R08
    if (reg_wr && sise_hit(reg_addr, SISE_OFF_INTERRUPT_STATUS, cfg_xip)) begin
      tog_v = reg_wdata[13:0]; // R13
    end
    if (reg_wr && sise_hit(reg_addr, SISE_OFF_INTERRUPT_ENABLE, cfg_xip)) begin
      st_d.enable = reg_wdata[13:0]; // R15
    end
    if (reg_wr && sise_hit(reg_addr, SISE_OFF_GLOBAL_IRQ_GATE_REG, cfg_xip)) begin
      st_d.gate = reg_wdata[SISE_GLOBAL_IRQ_GATE_BIT]; // R20
    end
    // Set is ORed after the toggle so an event never disappears under a write.
    st_d.status = (st_q.status ^ tog_v) | set_v; // R13 R22
    st_d.irq = st_d.gate &&
               |(st_d.status & sise_eff_en(st_d.enable, cfg_dual_quad, cfg_master, cfg_fifo_present)); // R14 R20
    st_d.start_allow = !st_d.status[SISE_B_TX_EMPTY]; // R10
    if (reg_rd) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = '0;
      if (sise_hit(reg_addr, SISE_OFF_INTERRUPT_STATUS, cfg_xip)) begin
        st_d.rdata[13:0] = st_q.status;
        if (!cfg_fifo_present) begin
          st_d.rdata[SISE_B_RX_NOT_EMPTY] = 1'b0; // R02
        end
      end else if (sise_hit(reg_addr, SISE_OFF_INTERRUPT_ENABLE, cfg_xip)) begin
        st_d.rdata[13:0] = st_q.enable; // R15
      end else if (sise_hit(reg_addr, SISE_OFF_GLOBAL_IRQ_GATE_REG, cfg_xip)) begin
        st_d.rdata[SISE_GLOBAL_IRQ_GATE_BIT] = st_q.gate;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{status: SISE_STATUS_RST, enable: SISE_ENABLE_RST, gate: SISE_GATE_RST, ss_prev: 1'b0,
                occ_prev: 8'h00, irq: 1'b0, rdata: 32'h0000_0000, rvalid: 1'b0, load_zero: 1'b0,
                start_allow: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;
  assign irq = st_q.irq;
  assign tx_load_zero = st_q.load_zero;
  assign master_start_allow = st_q.start_allow;

  property p_rx_not_empty;
    @(posedge sys_clk) disable iff (!rst_n)
    rx_first_beat && cfg_fifo_present && !cfg_dual_quad && !cfg_master |=> st_q.status[SISE_B_RX_NOT_EMPTY];
  endproperty
  a_rx_not_empty: assert property (p_rx_not_empty) else $error("receive not-empty event lost"); // R01

  property p_no_fifo_read;
    @(posedge sys_clk) disable iff (!rst_n)
    reg_rd && !cfg_fifo_present && reg_addr == SISE_OFF_INTERRUPT_STATUS |=> !reg_rdata[SISE_B_RX_NOT_EMPTY];
  endproperty
  a_no_fifo_read: assert property (p_no_fifo_read) else $error("bit 8 read nonzero without FIFOs"); // R02

  property p_selected;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(ss_active) && !cfg_dual_quad && !cfg_master ##1 1'b1 |-> st_q.status[SISE_B_SLAVE_SELECTED];
  endproperty
  a_selected: assert property (p_selected) else $error("slave selected event lost"); // R03

  property p_half_empty;
    @(posedge sys_clk) disable iff (!rst_n)
    cfg_fifo_present && !cfg_depth_256 && st_q.occ_prev == SISE_HALF_16 && tx_occupancy == 8'h07
    |=> st_q.status[SISE_B_TX_HALF_EMPTY];
  endproperty
  a_half_empty: assert property (p_half_empty) else $error("half-empty crossing missed"); // R04

  property p_underrun;
    @(posedge sys_clk) disable iff (!rst_n)
    element_end && tx_req_empty && serial_enable_bit && !cfg_dual_quad && !cfg_master
    |=> tx_load_zero && st_q.status[SISE_B_TX_UNDERRUN] ##1 (!tx_load_zero || $past(element_end));
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not flagged or zero load missing"); // R07 R08

  property p_start_block;
    @(posedge sys_clk) disable iff (!rst_n)
    element_end && (!cfg_fifo_present || tx_fifo_emptied) |=> !master_start_allow && st_q.status[SISE_B_TX_EMPTY];
  endproperty
  a_start_block: assert property (p_start_block) else $error("transfer allowed while transmit empty set"); // R09 R10

  property p_slave_fault_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (ss_active && !cfg_master && !serial_enable_bit)[*2] |=> st_q.status[SISE_B_DISABLED_TARGET_FAULT];
  endproperty
  a_slave_fault_hold: assert property (p_slave_fault_hold) else $error("disabled select fault not held"); // R11

  property p_master_fault;
    @(posedge sys_clk) disable iff (!rst_n)
    cfg_master && $rose(ss_active) ##1 1'b1 |-> st_q.status[SISE_B_MASTER_SELECT_FAULT];
  endproperty
  a_master_fault: assert property (p_master_fault) else $error("master select fault missed"); // R12

  property p_toggle;
    @(posedge sys_clk) disable iff (!rst_n)
    reg_wr && !cfg_xip && reg_addr == SISE_OFF_INTERRUPT_STATUS && reg_wdata[SISE_B_RX_FULL] && !element_end
    |=> st_q.status[SISE_B_RX_FULL] != $past(st_q.status[SISE_B_RX_FULL]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("write of one did not toggle"); // R13

  property p_set_wins;
    @(posedge sys_clk) disable iff (!rst_n)
    reg_wr && !cfg_xip && reg_addr == SISE_OFF_INTERRUPT_STATUS && reg_wdata[SISE_B_RX_FULL] && element_end
    && !cfg_fifo_present |=> st_q.status[SISE_B_RX_FULL];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost under toggle write"); // R22

  property p_gate;
    @(posedge sys_clk) disable iff (!rst_n)
    irq |-> st_q.gate && |(st_q.status & st_q.enable);
  endproperty
  a_gate: assert property (p_gate) else $error("interrupt without gate or enabled status"); // R14 R20

  property p_master_mask;
    @(posedge sys_clk) disable iff (!rst_n)
    irq && cfg_master && $past(cfg_master) |-> |(st_q.status & st_q.enable & 14'h3F7F);
  endproperty
  a_master_mask: assert property (p_master_mask) else $error("slave-selected enable raised interrupt"); // R17

  property p_overrun;
    @(posedge sys_clk) disable iff (!rst_n)
    rx_store_try && rx_buf_full && (!cfg_dual_quad || cfg_master) |=> st_q.status[SISE_B_RX_OVERRUN];
  endproperty
  a_overrun: assert property (p_overrun) else $error("receive overrun event lost"); // R05

  property p_full_no_fifo;
    @(posedge sys_clk) disable iff (!rst_n)
    element_end && !cfg_fifo_present |=> st_q.status[SISE_B_RX_FULL];
  endproperty
  a_full_no_fifo: assert property (p_full_no_fifo) else $error("receive full not set per element"); // R06

  // With FIFOs a plain element end must not raise the full flag; only the filling transfer does.
  property p_full_fifo_quiet;
    @(posedge sys_clk) disable iff (!rst_n)
    cfg_fifo_present && !rx_fifo_filled && !st_q.status[SISE_B_RX_FULL] &&
    !(reg_wr && reg_addr == SISE_OFF_INTERRUPT_STATUS) |=> !st_q.status[SISE_B_RX_FULL];
  endproperty
  a_full_fifo_quiet: assert property (p_full_fifo_quiet) else $error("receive full set before FIFO filled"); // R06

  property p_pol_pha;
    @(posedge sys_clk) disable iff (!rst_n)
    cfg_dual_quad && (cfg_cpol != cfg_cpha) |=> st_q.status[SISE_B_POL_PHA_ERR];
  endproperty
  a_pol_pha: assert property (p_pol_pha) else $error("polarity and phase error missed"); // R21

  property p_std_quiet;
    @(posedge sys_clk) disable iff (!rst_n)
    !cfg_dual_quad && !st_q.status[SISE_B_CMD_ERR] && !(reg_wr && reg_addr == SISE_OFF_INTERRUPT_STATUS)
    |=> !st_q.status[SISE_B_CMD_ERR];
  endproperty
  a_std_quiet: assert property (p_std_quiet) else $error("command error set outside dual or quad"); // R23

  property p_enable_wr;
    @(posedge sys_clk) disable iff (!rst_n)
    reg_wr && !cfg_xip && reg_addr == SISE_OFF_INTERRUPT_ENABLE
    |=> {18'h0, st_q.enable} == ($past(reg_wdata) & 32'h0000_3FFF);
  endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("enable write did not land"); // R15

  // Bit 4 is never masked by the configuration, so it shows the positive side of the gating.
  property p_irq_on;
    @(posedge sys_clk) disable iff (!rst_n)
    st_q.gate && st_q.status[SISE_B_RX_FULL] && st_q.enable[SISE_B_RX_FULL] |-> irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("enabled status did not raise interrupt"); // R14 R20

endmodule : sise_irq_ctrl

`default_nettype wire

// >>> tb/spi_interrupt_status_enable_bench.sv
// Self-checking bench for the SPI interrupt status, enable and global gate block.
`timescale 1ns/1ps
`default_nettype none
module spi_interrupt_status_enable_bench import sise_pkg::*;;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic [7:0] cfg = 8'h00;
  logic ss = 1'b0;
  logic [7:0] occ = 8'h00;
  logic rx_full = 1'b0;
  logic [9:0] ev = 10'h000;
  logic irq;
  logic tx_load_zero;
  logic master_start_allow;
  int error_cnt = 0;
  int cmp_count = 0;
  int zcnt;
  logic [31:0] d;
  logic [31:0] w;
  logic [3:0] bt [3] = '{4'h9, 4'h7, 4'h8};
  logic [7:0] con [3] = '{8'h05, 8'h01, 8'h09};
  logic [7:0] coff [3] = '{8'h01, 8'h09, 8'h08};
  logic [7:0] cpc [3] = '{8'hCC, 8'h4C, 8'h8C};

  // Config bits: 0 fifo, 1 depth 256, 2 dual/quad, 3 master, 4 xip, 5 enable, 6 cpol, 7 cpha.
  sise_irq_ctrl u_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .cfg_fifo_present(cfg[0]), .cfg_depth_256(cfg[1]), .cfg_dual_quad(cfg[2]), .cfg_master(cfg[3]),
    .cfg_xip(cfg[4]), .serial_enable_bit(cfg[5]), .cfg_cpol(cfg[6]), .cfg_cpha(cfg[7]),
    .ss_active(ss), .rx_first_beat(ev[0]), .tx_occupancy(occ), .rx_store_try(ev[1]), .rx_buf_full(rx_full),
    .element_end(ev[2]), .rx_fifo_filled(ev[3]), .tx_req_empty(ev[4]), .tx_fifo_emptied(ev[5]),
    .cmd_err_strobe(ev[6]), .loop_err_strobe(ev[7]), .msb_err_strobe(ev[8]), .slv_mode_err_strobe(ev[9]),
    .irq(irq), .tx_load_zero(tx_load_zero), .master_start_allow(master_start_allow));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // The polarity and phase error exists only in dual or quad mode with the two control bits unequal.
  function automatic logic [31:0] exp_pol_pha(input logic [7:0] c);
    exp_pol_pha = (c[2] && (c[6] != c[7])) ? 32'h0000_0200 : 32'h0000_0000;
  endfunction : exp_pol_pha

  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Waits a bounded number of edges for the read answer; no answer leaves unknowns that fail compares.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    v = 'x;
    for (int i = 0; i < 3; i++) begin
      #1;
      if (reg_rvalid === 1'b1) begin
        v = reg_rdata;
        break;
      end
      @(posedge sys_clk);
    end
  endtask : rd

  task automatic setcfg(input logic [7:0] c);
    @(posedge sys_clk);
    cfg <= c;
    @(posedge sys_clk);
  endtask : setcfg

  task automatic sel(input logic v);
    @(posedge sys_clk);
    ss <= v;
    settle();
  endtask : sel

  task automatic fire(input logic [9:0] msk);
    @(posedge sys_clk);
    ev <= msk;
    @(posedge sys_clk);
    ev <= 10'h000;
    zcnt = 0;
    for (int i = 0; i < 3; i++) begin
      #1;
      if (tx_load_zero === 1'b1) zcnt++;
      @(posedge sys_clk);
    end
    #1;
  endtask : fire

  // Reads the status, compares the masked bits, then writes the read value back to clear them.
  task automatic st(input string name, input logic [31:0] msk, input logic [31:0] exp);
    rd(SISE_OFF_INTERRUPT_STATUS, d);
    chk(name, exp, d & msk);
    wr(SISE_OFF_INTERRUPT_STATUS, d & 32'h3FFF);
  endtask : st

  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    results();
  end

  initial begin
    void'($urandom(67060));
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("irq_rst", 32'h0, 32'(irq));
    chk("allow_rst", 32'h1, 32'(master_start_allow));
    rd(SISE_OFF_GLOBAL_IRQ_GATE_REG, d);
    chk("gate_rst", 32'h0, d);
    rd(SISE_OFF_INTERRUPT_ENABLE, d);
    chk("enable_rst", 32'h0, d);
    st("status_rst", 32'hFFFFFFFF, 32'h0);
    rd(8'h04, d);
    chk("unmapped", 32'h0, d);
    $display("test reset done");
    setcfg(8'h01);
    for (int k = 0; k < 8; k++) begin
      w = $urandom();
      wr(SISE_OFF_INTERRUPT_ENABLE, w);
      rd(SISE_OFF_INTERRUPT_ENABLE, d);
      chk("enable_rw", w & 32'h3FFF, d);
      wr(SISE_OFF_INTERRUPT_STATUS, w);
      wr(SISE_OFF_INTERRUPT_STATUS, 32'h0);
      st("status_toggle", 32'hFFFFFFFF, w & 32'h3FFF);
      st("status_cleared", 32'hFFFFFFFF, 32'h0);
    end
    wr(SISE_OFF_GLOBAL_IRQ_GATE_REG, 32'hFFFFFFFF);
    rd(SISE_OFF_GLOBAL_IRQ_GATE_REG, d);
    chk("gate_rw", 32'h80000000, d);
    $display("test registers done");
    setcfg(8'h08);
    wr(SISE_OFF_INTERRUPT_ENABLE, 32'h10);
    fire(10'h004);
    chk("allow_low", 32'h0, 32'(master_start_allow));
    chk("irq_on", 32'h1, 32'(irq));
    wr(SISE_OFF_GLOBAL_IRQ_GATE_REG, 32'h0);
    settle();
    chk("irq_gated", 32'h0, 32'(irq));
    st("elem_nofifo", 32'h14, 32'h14);
    settle();
    chk("allow_high", 32'h1, 32'(master_start_allow));
    // With FIFOs a plain element end is not enough; only the fill and drain transfers count.
    setcfg(8'h09);
    fire(10'h004);
    st("elem_fifo", 32'h14, 32'h0);
    fire(10'h02C);
    st("fill_drain", 32'h14, 32'h14);
    rx_full <= 1'b1;
    fire(10'h002);
    @(posedge sys_clk);
    rx_full <= 1'b0;
    st("overrun", 32'h20, 32'h20);
    for (int k = 0; k < 2; k++) begin
      setcfg(k == 0 ? 8'h01 : 8'h03);
      occ <= (k == 0) ? SISE_HALF_16 : SISE_HALF_256;
      @(posedge sys_clk);
      occ <= ((k == 0) ? SISE_HALF_16 : SISE_HALF_256) - 8'h01;
      settle();
      st("half_empty", 32'h40, 32'h40);
    end
    $display("test transfer events done");
    setcfg(8'h08);
    sel(1'b1);
    sel(1'b0);
    st("master_select", 32'h83, 32'h01);
    setcfg(8'h00);
    sel(1'b1);
    st("slave_disabled", 32'h02, 32'h02);
    st("slave_disabled_held", 32'h02, 32'h02);
    sel(1'b0);
    st("slave_fault_left", 32'h02, 32'h02);
    st("slave_fault_gone", 32'h02, 32'h0);
    setcfg(8'h20);
    sel(1'b1);
    sel(1'b0);
    st("slave_selected", 32'h83, 32'h80);
    setcfg(8'h24);
    sel(1'b1);
    sel(1'b0);
    st("dual_selected", 32'h80, 32'h0);
    $display("test select done");
    setcfg(8'h20);
    fire(10'h014);
    chk("zero_load", 32'h1, 32'(zcnt));
    st("underrun", 32'h08, 32'h08);
    setcfg(8'h00);
    fire(10'h014);
    chk("zero_load_off", 32'h0, 32'(zcnt));
    st("underrun_off", 32'h08, 32'h0);
    setcfg(8'h01);
    fire(10'h001);
    st("first_beat", 32'h100, 32'h100);
    setcfg(8'h00);
    fire(10'h001);
    wr(SISE_OFF_INTERRUPT_STATUS, 32'h100);
    st("first_beat_nofifo", 32'h100, 32'h0);
    $display("test underrun and receive done");
    setcfg(8'h0C);
    for (int i = 0; i < 4; i++) begin
      fire(10'h040 << i);
      st("dual_error", 32'h3C00, 32'h1 << (13 - i));
    end
    setcfg(8'h08);
    fire(10'h3C0);
    st("std_error", 32'h3E00, 32'h0);
    for (int i = 0; i < 3; i++) begin
      setcfg(cpc[i]);
      settle();
      st("pol_pha", 32'h200, exp_pol_pha(cpc[i]));
      setcfg(8'h0C);
      st("pol_pha_held", 32'h200, exp_pol_pha(cpc[i]));
    end
    fire(10'h004);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= SISE_OFF_INTERRUPT_STATUS;
    reg_wdata <= 32'h10;
    ev <= 10'h004;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    ev <= 10'h000;
    settle();
    st("set_wins", 32'h10, 32'h10);
    $display("test errors done");
    wr(SISE_OFF_GLOBAL_IRQ_GATE_REG, 32'h80000000);
    for (int i = 0; i < 3; i++) begin
      setcfg(con[i]);
      wr(SISE_OFF_INTERRUPT_STATUS, 32'h1 << bt[i]);
      wr(SISE_OFF_INTERRUPT_ENABLE, 32'h1 << bt[i]);
      settle();
      chk("irq_masked_on", 32'h1, 32'(irq));
      setcfg(coff[i]);
      settle();
      chk("irq_masked_off", 32'h0, 32'(irq));
      setcfg(con[i]);
      st("mask_kept", 32'h1 << bt[i], 32'h1 << bt[i]);
    end
    setcfg(8'h10);
    wr(SISE_OFF_INTERRUPT_ENABLE, 32'h3FFF);
    rd(SISE_OFF_INTERRUPT_ENABLE, d);
    chk("xip_hidden", 32'h0, d);
    $display("test masks done");
    results();
  end
endmodule : spi_interrupt_status_enable_bench
`default_nettype wire
